// ==== atu_address_translation_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Fully associative dual-ported joint buffer, 16-64 pairs
// - Tag match uses upper address and space tag
// - Page sizes 4KB to 256MB, step four
// - Tag owns even/odd entry, next bit selects
// - Compare bits and select bit chosen per entry
// - Mixed page sizes coexist and translate correctly
// - Fetch checks micro buffer, joint hit refills it
// - Fetch missing both buffers raises miss exception
// - Data uses joint buffer only, miss raises exception
// - Micro buffer four entries, 4KB or 16KB
// - Larger pages map current 16KB subpage
// - Micro buffer fully hardware managed
// - Joint lookup next cycle or when port free
// - Refill port shared with management writes
// - Parameter selects buffer or fixed mapping
// - Fixed mapping keeps kernel segments identical
// - Fixed mapping removes supervisor mode
// - Data lookup in cache access stage
module atu_address_translation_unit import atu_pkg::*; #(
	parameter int JOINT_TRANSLATION_BUFFER_ENTRIES = 64,
	parameter bit USE_FIXED_MAP = 1'b0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ADDRESS_SPACE_TAG_W-1:0] curAsid,
	input wire logic [ATTR_W-1:0] kernelAttr,
	input wire logic mgmtWr,
	input wire logic [IDX_W-1:0] mgmtIdx,
	input wire logic [VPN2_W-1:0] mgmtVpn2,
	input wire logic [MASK_W-1:0] mgmtMask,
	input wire logic [ADDRESS_SPACE_TAG_W-1:0] mgmtAsid,
	input wire logic mgmtGlobal,
	input wire logic [LO_W-1:0] mgmtLoEven,
	input wire logic [LO_W-1:0] mgmtLoOdd,
	input wire logic iReq,
	input wire logic [VA_W-1:0] iVaddr,
	output logic iReady,
	output logic iDone,
	output logic iMiss,
	output logic [VA_W-1:0] iPaddr,
	output logic [ATTR_W-1:0] iAttr,
	input wire logic dReq,
	input wire logic [VA_W-1:0] dVaddr,
	output logic dDone,
	output logic dMiss,
	output logic dDirty,
	output logic [VA_W-1:0] dPaddr,
	output logic [ATTR_W-1:0] dAttr,
	output logic supervisorAvail
);
	// Joint buffer storage, one tag and two page words per slot
	logic [JOINT_TRANSLATION_BUFFER_ENTRIES-1:0] used_q, used_d;
	logic [VPN2_W-1:0] tagVpn_q [JOINT_TRANSLATION_BUFFER_ENTRIES], tagVpn_d [JOINT_TRANSLATION_BUFFER_ENTRIES];
	logic [MASK_W-1:0] mask_q [JOINT_TRANSLATION_BUFFER_ENTRIES], mask_d [JOINT_TRANSLATION_BUFFER_ENTRIES];
	logic [ADDRESS_SPACE_TAG_W-1:0] address_space_tag_q [JOINT_TRANSLATION_BUFFER_ENTRIES], address_space_tag_d [JOINT_TRANSLATION_BUFFER_ENTRIES];
	logic [JOINT_TRANSLATION_BUFFER_ENTRIES-1:0] glob_q, glob_d;
	logic [LO_W-1:0] loEven_q [JOINT_TRANSLATION_BUFFER_ENTRIES], loEven_d [JOINT_TRANSLATION_BUFFER_ENTRIES];
	logic [LO_W-1:0] loOdd_q [JOINT_TRANSLATION_BUFFER_ENTRIES], loOdd_d [JOINT_TRANSLATION_BUFFER_ENTRIES];
	// Per-slot compare results for data port and refill port
	logic [JOINT_TRANSLATION_BUFFER_ENTRIES-1:0] hitD, hitR, oddD, oddR;
	// Micro buffer storage
	logic [UTLB_N-1:0] uVal_q, uVal_d;
	logic [UTLB_N-1:0] uBig_q, uBig_d;
	logic [UTLB_N-1:0] uGlob_q, uGlob_d;
	logic [PN_W-1:0] uVpn_q [UTLB_N], uVpn_d [UTLB_N];
	logic [PN_W-1:0] uPpn_q [UTLB_N], uPpn_d [UTLB_N];
	logic [ADDRESS_SPACE_TAG_W-1:0] uAsid_q [UTLB_N], uAsid_d [UTLB_N];
	logic [ATTR_W-1:0] uAttr_q [UTLB_N], uAttr_d [UTLB_N];
	logic [1:0] uAge_q [UTLB_N], uAge_d [UTLB_N];
	logic [UTLB_N-1:0] uHit;
	// Fetch sequencing
	atu_state_t state_q, state_d;
	logic [VA_W-1:0] reqVa_q, reqVa_d;
	logic [ADDRESS_SPACE_TAG_W-1:0] reqAsid_q, reqAsid_d;
	// Registered outputs
	logic iReady_q, iReady_d, iDone_q, iDone_d, iMiss_q, iMiss_d;
	logic [VA_W-1:0] iPaddr_q, iPaddr_d, dPaddr_q, dPaddr_d;
	logic [ATTR_W-1:0] iAttr_q, iAttr_d, dAttr_q, dAttr_d;
	logic dDone_q, dDone_d, dMiss_q, dMiss_d, dDirty_q, dDirty_d;
	logic supAvail_q;
	// Search results
	atu_match_t mD, mR;
	logic [1:0] touchIdx;
	logic touch;

	// Unmapped decode; returns {unmapped, pa, attr}
	function automatic logic [VA_W+ATTR_W:0] segMap(input logic [VA_W-1:0] va,
			input logic [ATTR_W-1:0] kAttr);
		logic [VA_W-1:0] pa;
		pa = {3'h0, va[VA_W-4:0]};
		if (va[VA_W-1 -: 3] == SEG_CACHED_KERNEL) begin
			return {1'b1, pa, kAttr};
		end else if (va[VA_W-1 -: 3] == SEG_UNCACHED_KERNEL) begin
			return {1'b1, pa, ATTR_UNCACHED};
		end else if (!USE_FIXED_MAP) begin
			return '0;
		end else if (!va[VA_W-1]) begin
			return {1'b1, va + FIXED_USER_OFFSET, kAttr};
		end else begin
			// Upper kernel space maps to itself
			return {1'b1, va, kAttr};
		end
	endfunction

	// First matching slot; an invalid page word reports a miss
	function automatic atu_match_t pick(input logic [JOINT_TRANSLATION_BUFFER_ENTRIES-1:0] hits,
			input logic [JOINT_TRANSLATION_BUFFER_ENTRIES-1:0] odd, input logic [VA_W-1:0] va);
		atu_match_t r;
		logic found;
		logic [LO_W-1:0] lo;
		logic [PN_W-1:0] om;
		r = '0;
		found = 1'b0;
		for (int i = 0; i < JOINT_TRANSLATION_BUFFER_ENTRIES; i++) begin
			if (hits[i] && !found) begin
				found = 1'b1;
				// select bit picks even or odd word
				lo = odd[i] ? loOdd_q[i] : loEven_q[i];
				// offset bits taken from the address
				om = {4'h0, mask_q[i]};
				r.hit = lo[LO_VALID_BIT];
				r.pfn = (lo[LO_PFN_LSB +: PN_W] & ~om) | (va[VA_W-1 -: PN_W] & om);
				r.attr = lo[LO_ATTR_LSB +: ATTR_W];
				r.dirty = lo[LO_DIRTY_BIT];
				r.big = |mask_q[i];
			end
		end
		return r;
	endfunction

	// every slot compared on both ports at once
	for (genvar g = 0; g < JOINT_TRANSLATION_BUFFER_ENTRIES; g++) begin : gJtlb
		logic [VPN2_W-1:0] cmp;
		logic [MASK_W:0] sel;
		// compare mask comes from this slot
		assign cmp = ~{3'h0, mask_q[g]};
		// select bit is just above the offset
		assign sel = {mask_q[g], 1'b1} & ~{1'b0, mask_q[g]};
		// address and space tag against each tag
		assign hitD[g] = used_q[g] && ((dVaddr[VA_W-1 -: VPN2_W] & cmp) == (tagVpn_q[g] & cmp))
			&& (glob_q[g] || address_space_tag_q[g] == curAsid);
		assign hitR[g] = used_q[g] && ((reqVa_q[VA_W-1 -: VPN2_W] & cmp) == (tagVpn_q[g] & cmp))
			&& (glob_q[g] || address_space_tag_q[g] == reqAsid_q);
		assign oddD[g] = |(dVaddr[VA_W-4:12] & sel);
		assign oddR[g] = |(reqVa_q[VA_W-4:12] & sel);
	end

	// mixed sizes resolved per slot above
	// A process, so page-word writes re-evaluate the search
	always_comb begin
		mD = pick(hitD, oddD, dVaddr);
		mR = pick(hitR, oddR, reqVa_q);
	end

	// Micro buffer compare; a 16KB entry ignores the two low page bits
	for (genvar k = 0; k < UTLB_N; k++) begin : gMicro
		assign uHit[k] = uVal_q[k] && (uGlob_q[k] || uAsid_q[k] == curAsid)
			&& (((iVaddr[VA_W-1 -: PN_W] ^ uVpn_q[k]) & {18'h3ffff, {2{~uBig_q[k]}}}) == '0);
	end

	// Management writes into the joint buffer
	always_comb begin
		used_d = used_q;
		tagVpn_d = tagVpn_q;
		mask_d = mask_q;
		address_space_tag_d = address_space_tag_q;
		glob_d = glob_q;
		loEven_d = loEven_q;
		loOdd_d = loOdd_q;
		// Indices past the built size are dropped
		if (mgmtWr && int'(mgmtIdx) < JOINT_TRANSLATION_BUFFER_ENTRIES) begin
			used_d[mgmtIdx] = 1'b1;
			tagVpn_d[mgmtIdx] = mgmtVpn2;
			mask_d[mgmtIdx] = mgmtMask;
			address_space_tag_d[mgmtIdx] = mgmtAsid;
			glob_d[mgmtIdx] = mgmtGlobal;
			loEven_d[mgmtIdx] = mgmtLoEven;
			loOdd_d[mgmtIdx] = mgmtLoOdd;
		end
	end

	// Joint buffer registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			used_q <= '0;
		end else begin
			used_q <= used_d;
		end
		tagVpn_q <= tagVpn_d;
		mask_q <= mask_d;
		address_space_tag_q <= address_space_tag_d;
		glob_q <= glob_d;
		loEven_q <= loEven_d;
		loOdd_q <= loOdd_d;
	end

	// Data port, answered one cycle after the request
	always_comb begin
		logic [VA_W+ATTR_W:0] sm;
		sm = segMap(dVaddr, kernelAttr);
		dDone_d = dReq;
		// looked up alongside the cache access
		if (sm[VA_W+ATTR_W]) begin
			dMiss_d = 1'b0;
			dDirty_d = 1'b1;
			dPaddr_d = sm[ATTR_W +: VA_W];
			dAttr_d = sm[ATTR_W-1:0];
		end else begin
			dMiss_d = dReq && !mD.hit;
			dDirty_d = mD.dirty;
			dPaddr_d = {mD.pfn, dVaddr[11:0]};
			dAttr_d = mD.attr;
		end
	end

	// Fetch sequencing and micro buffer upkeep
	always_comb begin
		logic [VA_W+ATTR_W:0] sm;
		logic [1:0] vic;
		sm = segMap(iVaddr, kernelAttr);
		vic = 2'h0;
		state_d = state_q;
		reqVa_d = reqVa_q;
		reqAsid_d = reqAsid_q;
		iDone_d = 1'b0;
		iMiss_d = 1'b0;
		iPaddr_d = iPaddr_q;
		iAttr_d = iAttr_q;
		uVal_d = uVal_q;
		uBig_d = uBig_q;
		uGlob_d = uGlob_q;
		uVpn_d = uVpn_q;
		uPpn_d = uPpn_q;
		uAsid_d = uAsid_q;
		uAttr_d = uAttr_q;
		touch = 1'b0;
		touchIdx = 2'h0;
		for (int v = UTLB_N - 1; v >= 0; v--) begin
			if (uAge_q[v] == 2'h3) begin
				vic = 2'(v);
			end
		end
		for (int v = UTLB_N - 1; v >= 0; v--) begin
			if (!uVal_q[v]) begin
				vic = 2'(v);
			end
		end
		unique case (state_q)
			AtuIdle: begin
				if (iReq && iReady_q) begin
					reqVa_d = iVaddr;
					reqAsid_d = curAsid;
					if (sm[VA_W+ATTR_W]) begin
						iDone_d = 1'b1;
						iPaddr_d = sm[ATTR_W +: VA_W];
						iAttr_d = sm[ATTR_W-1:0];
					end else if (|uHit) begin
						iDone_d = 1'b1;
						touch = 1'b1;
						for (int h = 0; h < UTLB_N; h++) begin
							if (uHit[h]) begin
								touchIdx = 2'(h);
							end
						end
						iPaddr_d = {uBig_q[touchIdx] ? {uPpn_q[touchIdx][PN_W-1:2], iVaddr[13:12]}
							: uPpn_q[touchIdx], iVaddr[11:0]};
						iAttr_d = uAttr_q[touchIdx];
					end else begin
						// fall back to the joint buffer
						state_d = AtuRefill;
					end
				end
			end
			AtuRefill: begin
				// waits while management owns the port
				if (!mgmtWr) begin
					state_d = AtuIdle;
					iDone_d = 1'b1;
					iMiss_d = !mR.hit;
					iPaddr_d = {mR.pfn, reqVa_q[11:0]};
					iAttr_d = mR.attr;
					if (mR.hit) begin
						touch = 1'b1;
						touchIdx = vic;
						uVal_d[vic] = 1'b1;
						uBig_d[vic] = mR.big;
						uGlob_d[vic] = 1'b0;
						uVpn_d[vic] = reqVa_q[VA_W-1 -: PN_W];
						uPpn_d[vic] = mR.pfn;
						uAsid_d[vic] = reqAsid_q;
						uAttr_d[vic] = mR.attr;
					end
				end
			end
		endcase
		// any joint change flushes the micro buffer
		if (mgmtWr) begin
			uVal_d = '0;
		end
		iReady_d = (state_d == AtuIdle);
	end

	// age update keeps ages a permutation of 0..3
	for (genvar a = 0; a < UTLB_N; a++) begin : gAge
		always_comb begin
			uAge_d[a] = uAge_q[a];
			if (touch) begin
				if (touchIdx == 2'(a)) begin
					uAge_d[a] = 2'h0;
				end else if (uAge_q[a] < uAge_q[touchIdx]) begin
					uAge_d[a] = uAge_q[a] + 2'h1;
				end
			end
		end
	end

	// Fetch, micro buffer and output registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= AtuIdle;
			uVal_q <= '0;
			for (int r = 0; r < UTLB_N; r++) begin
				uAge_q[r] <= UAGE_RST_STEP * 2'(r);
			end
			iReady_q <= 1'b0;
			iDone_q <= 1'b0;
			iMiss_q <= 1'b0;
			iPaddr_q <= '0;
			iAttr_q <= '0;
			dDone_q <= 1'b0;
			dMiss_q <= 1'b0;
			dDirty_q <= 1'b0;
			dPaddr_q <= '0;
			dAttr_q <= '0;
			reqVa_q <= '0;
			reqAsid_q <= '0;
			// supervisor only with the buffer style
			supAvail_q <= !USE_FIXED_MAP;
		end else begin
			state_q <= state_d;
			uVal_q <= uVal_d;
			uAge_q <= uAge_d;
			iReady_q <= iReady_d;
			iDone_q <= iDone_d;
			iMiss_q <= iMiss_d;
			iPaddr_q <= iPaddr_d;
			iAttr_q <= iAttr_d;
			dDone_q <= dDone_d;
			dMiss_q <= dMiss_d;
			dDirty_q <= dDirty_d;
			dPaddr_q <= dPaddr_d;
			dAttr_q <= dAttr_d;
			reqVa_q <= reqVa_d;
			reqAsid_q <= reqAsid_d;
			supAvail_q <= supAvail_q;
		end
		// Entry payload needs no reset; valid bits guard it
		uBig_q <= uBig_d;
		uGlob_q <= uGlob_d;
		uVpn_q <= uVpn_d;
		uPpn_q <= uPpn_d;
		uAsid_q <= uAsid_d;
		uAttr_q <= uAttr_d;
	end

	assign iReady = iReady_q;
	assign iDone = iDone_q;
	assign iMiss = iMiss_q;
	assign iPaddr = iPaddr_q;
	assign iAttr = iAttr_q;
	assign dDone = dDone_q;
	assign dMiss = dMiss_q;
	assign dDirty = dDirty_q;
	assign dPaddr = dPaddr_q;
	assign dAttr = dAttr_q;
	assign supervisorAvail = supAvail_q;
endmodule // atu_address_translation_unit
`default_nettype wire

// ==== atu_checker_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module atu_checker import atu_pkg::*; #(
	parameter int JOINT_TRANSLATION_BUFFER_ENTRIES = 64,
	parameter bit USE_FIXED_MAP = 1'b0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic dReq,
	input wire logic [VA_W-1:0] dVaddr,
	input wire logic dDone,
	input wire logic dMiss,
	input wire logic [VA_W-1:0] dPaddr,
	input wire logic [ATTR_W-1:0] dAttr,
	input wire logic iReq,
	input wire logic iReady,
	input wire logic [VA_W-1:0] iVaddr,
	input wire logic iDone,
	input wire logic iMiss,
	input wire logic mgmtWr,
	input wire logic supervisorAvail
);
	// Single core clock, so one default domain
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_DATA_ONE_CYCLE: assert property (dReq |=> dDone)
		else $error("data answer not one cycle after request");
	AST_DATA_NO_SPURIOUS: assert property (!dReq |=> !dDone)
		else $error("data answer without a request");
	AST_DATA_UNMAPPED: assert property (dReq && dVaddr[31:29] == SEG_UNCACHED_KERNEL |=>
		!dMiss && dAttr == ATTR_UNCACHED && dPaddr == {3'h0, $past(dVaddr[28:0])})
		else $error("uncached kernel data translation wrong");
	AST_FETCH_KERNEL: assert property (iReq && iReady && iVaddr[31:29] == SEG_CACHED_KERNEL
		|=> iDone && !iMiss)
		else $error("cached kernel fetch not answered next cycle");
	AST_FETCH_STEP: assert property (iReq && iReady |=> iDone || !iReady)
		else $error("fetch neither answered nor waiting");
	// Bound is generous: management writes may stretch the wait
	AST_REFILL_BOUND: assert property ($fell(iReady) |-> ##[1:16] iDone)
		else $error("refill answer late");
	AST_MGMT_HOLDS_REFILL: assert property (!iReady && mgmtWr |=> !iDone)
		else $error("refill not held off by management write");
	AST_DONE_READY: assert property (iDone |-> iReady)
		else $error("fetch answer while still refilling");
	AST_MODE_SEL: assert property (supervisorAvail == !USE_FIXED_MAP)
		else $error("supervisor availability wrong for mapping style");
	cover property (dDone && dMiss);
	cover property (iDone && iMiss);
	cover property ($rose(iReady) && iDone);
endmodule // atu_checker
bind atu_address_translation_unit atu_checker #(.JOINT_TRANSLATION_BUFFER_ENTRIES(JOINT_TRANSLATION_BUFFER_ENTRIES),
	.USE_FIXED_MAP(USE_FIXED_MAP)) chk (.clk(clk), .rst_b(rst_b), .dReq(dReq),
	.dVaddr(dVaddr), .dDone(dDone), .dMiss(dMiss), .dPaddr(dPaddr), .dAttr(dAttr),
	.iReq(iReq), .iReady(iReady), .iVaddr(iVaddr), .iDone(iDone), .iMiss(iMiss),
	.mgmtWr(mgmtWr), .supervisorAvail(supervisorAvail));
`default_nettype wire

// ==== atu_fetch_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module atu_fetch_model import atu_pkg::*; (
	input wire logic clk,
	input wire logic go,
	input wire logic [VA_W-1:0] goAddr,
	input wire logic iReady,
	output logic iReq,
	output logic [VA_W-1:0] iVaddr
);
	// Idle after time zero, no request pending
	initial begin
		iReq = 1'b0;
		iVaddr = '0;
	end
	// Request holds until an edge sees ready; a new go may follow at once
	always @(posedge clk) begin
		if (go) begin
			iReq <= 1'b1;
			iVaddr <= goAddr;
		end else if (iReq && iReady) begin
			iReq <= 1'b0;
			// Released address shows garbage, not a stale match
			iVaddr <= ~iVaddr;
		end
	end
endmodule // atu_fetch_model
`default_nettype wire

// ==== atu_pkg.sv ====
`default_nettype none
package atu_pkg;
	// Address and field widths
	localparam int VA_W = 32;
	localparam int PN_W = 20;
	localparam int VPN2_W = 19;
	localparam int MASK_W = 16;
	localparam int ADDRESS_SPACE_TAG_W = 8;
	localparam int ATTR_W = 3;
	localparam int IDX_W = 6;
	localparam int UTLB_N = 4;
	// Page-entry word: pfn, cache attribute, dirty, valid
	localparam int LO_W = 25;
	localparam int LO_PFN_LSB = 5;
	localparam int LO_ATTR_LSB = 2;
	localparam int LO_DIRTY_BIT = 1;
	localparam int LO_VALID_BIT = 0;
	// Unmapped kernel segments, selected by the top three address bits
	localparam logic [2:0] SEG_CACHED_KERNEL = 3'h4;
	localparam logic [2:0] SEG_UNCACHED_KERNEL = 3'h5;
	localparam logic [VA_W-1:0] FIXED_USER_OFFSET = 32'h4000_0000;
	localparam logic [ATTR_W-1:0] ATTR_UNCACHED = 3'h2;
	// Reset values
	localparam logic [1:0] UAGE_RST_STEP = 2'h1;
	// Result of one joint buffer search
	typedef struct packed {
		logic hit;
		logic [PN_W-1:0] pfn;
		logic [ATTR_W-1:0] attr;
		logic dirty;
		logic big;
	} atu_match_t;
	// Instruction side sequencing
	typedef enum logic {
		AtuIdle,
		AtuRefill
	} atu_state_t;
endpackage
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top import atu_pkg::*; ;
	logic clk, rst_b, mgmtWr, mgmtGlobal, go, dReq, iReq, iReady, iDone, iMiss;
	logic dDone, dMiss, dDirty, supervisorAvail, fxMiss, fxSuper;
	logic [ADDRESS_SPACE_TAG_W-1:0] curAsid, mgmtAsid;
	logic [IDX_W-1:0] mgmtIdx;
	logic [VPN2_W-1:0] mgmtVpn2;
	logic [MASK_W-1:0] mgmtMask;
	logic [LO_W-1:0] mgmtLoEven, mgmtLoOdd;
	logic [VA_W-1:0] goAddr, iVaddr, iPaddr, dVaddr, dPaddr, fxPaddr;
	logic [ATTR_W-1:0] iAttr, dAttr, kernelAttr, fxAttr;
	int miscompares, comparisons;
	// Attribute written into every test page word
	localparam logic [ATTR_W-1:0] PAGE_ATTR = 3'h3;
	atu_address_translation_unit dut (.clk(clk), .rst_b(rst_b), .curAsid(curAsid),
		.kernelAttr(kernelAttr), .mgmtWr(mgmtWr), .mgmtIdx(mgmtIdx), .mgmtVpn2(mgmtVpn2),
		.mgmtMask(mgmtMask), .mgmtAsid(mgmtAsid), .mgmtGlobal(mgmtGlobal),
		.mgmtLoEven(mgmtLoEven), .mgmtLoOdd(mgmtLoOdd), .iReq(iReq), .iVaddr(iVaddr),
		.iReady(iReady), .iDone(iDone), .iMiss(iMiss), .iPaddr(iPaddr), .iAttr(iAttr),
		.dReq(dReq), .dVaddr(dVaddr), .dDone(dDone), .dMiss(dMiss), .dDirty(dDirty),
		.dPaddr(dPaddr), .dAttr(dAttr), .supervisorAvail(supervisorAvail));
	// Same stimulus into the fixed mapping build
	atu_address_translation_unit #(.USE_FIXED_MAP(1'b1)) dutFix (.clk(clk), .rst_b(rst_b),
		.curAsid(curAsid), .kernelAttr(kernelAttr), .mgmtWr(mgmtWr), .mgmtIdx(mgmtIdx),
		.mgmtVpn2(mgmtVpn2), .mgmtMask(mgmtMask), .mgmtAsid(mgmtAsid), .mgmtGlobal(mgmtGlobal),
		.mgmtLoEven(mgmtLoEven), .mgmtLoOdd(mgmtLoOdd), .iReq(iReq), .iVaddr(iVaddr),
		.iReady(), .iDone(), .iMiss(), .iPaddr(), .iAttr(), .dReq(dReq), .dVaddr(dVaddr),
		.dDone(), .dMiss(fxMiss), .dDirty(), .dPaddr(fxPaddr), .dAttr(fxAttr),
		.supervisorAvail(fxSuper));
	// Fetch unit stand-in on the instruction port
	atu_fetch_model fetcher (.clk(clk), .go(go), .goAddr(goAddr), .iReady(iReady),
		.iReq(iReq), .iVaddr(iVaddr));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Verdict and end of run
	task automatic conclude();
		if (miscompares == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Case equality so unknowns never match
	task automatic chk(string name, logic [VA_W-1:0] exp, logic [VA_W-1:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One-cycle slot write, tag space 5, cached and valid page words
	task automatic wr(logic [IDX_W-1:0] idx, logic [VPN2_W-1:0] vpn2,
		logic [MASK_W-1:0] mask, logic glob, logic [PN_W-1:0] pe, logic [PN_W-1:0] po);
		@(posedge clk);
		mgmtWr <= 1'b1;
		mgmtIdx <= idx;
		mgmtVpn2 <= vpn2;
		mgmtMask <= mask;
		mgmtGlobal <= glob;
		mgmtLoEven <= {pe, PAGE_ATTR, 1'b0, 1'b1};
		mgmtLoOdd <= {po, PAGE_ATTR, 1'b0, 1'b1};
		@(posedge clk);
		mgmtWr <= 1'b0;
	endtask
	// Data lookup; answer stands right after the taking edge
	task automatic dLook(logic [VA_W-1:0] va, logic expMiss, logic [VA_W-1:0] expPa);
		logic unmapped;
		logic [ATTR_W-1:0] expAttr;
		logic [ATTR_W-1:0] fixAttr;
		logic [VA_W-1:0] fixPa;
		// Kernel segments bypass both builds; the fixed build shifts user space
		unmapped = va[31:29] == SEG_CACHED_KERNEL || va[31:29] == SEG_UNCACHED_KERNEL;
		fixAttr = (va[31:29] == SEG_UNCACHED_KERNEL) ? ATTR_UNCACHED : kernelAttr;
		expAttr = unmapped ? fixAttr : PAGE_ATTR;
		if (unmapped) begin
			fixPa = {3'h0, va[28:0]};
		end else if (!va[31]) begin
			fixPa = va + FIXED_USER_OFFSET;
		end else begin
			fixPa = va;
		end
		@(posedge clk);
		dReq <= 1'b1;
		dVaddr <= va;
		@(posedge clk);
		dReq <= 1'b0;
		dVaddr <= ~va;
		#1;
		chk("dDone", 32'h1, {31'h0, dDone});
		chk("dMiss", {31'h0, expMiss}, {31'h0, dMiss});
		if (!expMiss) begin
			chk("dPaddr", expPa, dPaddr);
			chk("dAttr", 32'(expAttr), 32'(dAttr));
			chk("dDirty", {31'h0, unmapped}, {31'h0, dDirty});
		end
		chk("fixMiss", 32'h0, {31'h0, fxMiss});
		chk("fixPaddr", fixPa, fxPaddr);
		chk("fixAttr", 32'(fixAttr), 32'(fxAttr));
	endtask
	// Fetch; latency counted in edges from the taking edge
	task automatic fetch(logic [VA_W-1:0] va, logic expMiss, logic [VA_W-1:0] expPa, int lat);
		int n;
		logic [ATTR_W-1:0] expAttr;
		// Kernel segments carry their own attribute, pages the written one
		if (va[31:29] == SEG_UNCACHED_KERNEL) begin
			expAttr = ATTR_UNCACHED;
		end else if (va[31:29] == SEG_CACHED_KERNEL) begin
			expAttr = kernelAttr;
		end else begin
			expAttr = PAGE_ATTR;
		end
		@(posedge clk);
		go <= 1'b1;
		goAddr <= va;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (iDone !== 1'b1 && n < 20);
		chk("iLatency", 32'(lat), 32'(n));
		chk("iMiss", {31'h0, expMiss}, {31'h0, iMiss});
		if (!expMiss) begin
			chk("iPaddr", expPa, iPaddr);
			chk("iAttr", 32'(expAttr), 32'(iAttr));
		end
	endtask
	task automatic t_data();
		dLook(32'h0040_0123, 1'b1, 32'h0);
		wr(6'h00, 19'h00200, 16'h0000, 1'b0, 20'h11111, 20'h22222);
		// Top slot holds a 16 MB global pair
		wr(6'h3f, 19'h03000, 16'h0fff, 1'b1, 20'h10000, 20'h20000);
		dLook(32'h0040_0123, 1'b0, 32'h1111_1123);
		dLook(32'h0040_1abc, 1'b0, 32'h2222_2abc);
		dLook(32'h0612_3456, 1'b0, 32'h1012_3456);
		dLook(32'h0712_3456, 1'b0, 32'h2012_3456);
		@(posedge clk);
		curAsid <= 8'h06;
		dLook(32'h0040_0123, 1'b1, 32'h0);
		dLook(32'h0612_3456, 1'b0, 32'h1012_3456);
		@(posedge clk);
		curAsid <= 8'h05;
		dLook(32'ha000_1234, 1'b0, 32'h0000_1234);
	endtask
	task automatic t_fetch();
		fetch(32'h8000_1000, 1'b0, 32'h0000_1000, 1);
		fetch(32'h0712_3456, 1'b0, 32'h2012_3456, 2);
		fetch(32'h0712_0010, 1'b0, 32'h2012_0010, 1);
		fetch(32'h0712_4000, 1'b0, 32'h2012_4000, 2);
		fetch(32'h0a00_0000, 1'b1, 32'h0, 2);
		fetch(32'h0040_0010, 1'b0, 32'h1111_1010, 2);
		fetch(32'h0040_0ff0, 1'b0, 32'h1111_1ff0, 1);
		fetch(32'h0040_1000, 1'b0, 32'h2222_2000, 2);
		// Fifth page evicts the least recently used entry
		fetch(32'h0612_0000, 1'b0, 32'h1012_0000, 2);
		fetch(32'h0712_4004, 1'b0, 32'h2012_4004, 1);
		fetch(32'h0712_0020, 1'b0, 32'h2012_0020, 2);
		wr(6'h02, 19'h7ff00, 16'h0000, 1'b0, 20'h33333, 20'h44444);
		fetch(32'h0712_4008, 1'b0, 32'h2012_4008, 2);
		// Write lands in the refill wait and costs one cycle
		fork
			fetch(32'h0040_0020, 1'b0, 32'h1111_1020, 3);
			begin
				repeat (2) @(posedge clk);
				wr(6'h02, 19'h7ff00, 16'h0000, 1'b0, 20'h33333, 20'h44444);
			end
		join
	endtask
	// Hang guard, well beyond the expected run
	initial begin
		#20000;
		miscompares++;
		conclude();
	end
	initial begin
		rst_b = 1'b0;
		curAsid = 8'h05;
		kernelAttr = 3'h1;
		mgmtAsid = 8'h05;
		{mgmtWr, mgmtGlobal, go, dReq} = 4'h0;
		{mgmtIdx, mgmtVpn2, mgmtMask} = '0;
		{mgmtLoEven, mgmtLoOdd} = '0;
		{goAddr, dVaddr} = '0;
		miscompares = 0;
		comparisons = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		chk("supervisorAvail", 32'h1, {31'h0, supervisorAvail});
		chk("fixSupervisor", 32'h0, {31'h0, fxSuper});
		t_data();
		t_fetch();
		conclude();
	end
endmodule // tb_top
`default_nettype wire
